// [inc/config_prom_map.vh]
// offsets, field positions, reset values and timing counts of the prom readout
`ifndef CONFIG_PROM_MAP_VH
`define CONFIG_PROM_MAP_VH

`define CLK_PERIOD_NS   25
// internal oscillator typical periods
`define OSC_FAST_NS     25
`define OSC_SLOW_NS     50
`define OSC_FAST_CYC    (((`OSC_FAST_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`OSC_FAST_NS / `CLK_PERIOD_NS))
`define OSC_SLOW_CYC    (((`OSC_SLOW_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`OSC_SLOW_NS / `CLK_PERIOD_NS))
// internal reset hold after rstn release, and reconfig pulse width
`define RST_HOLD_NS     400
`define RST_HOLD_CYC    ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CF_PULSE_NS     500
`define CF_PULSE_CYC    ((`CF_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_TERM        8'h08
`define REG_MEM_ADDR    8'h0c
`define REG_MEM_DATA    8'h10

// control fields
`define CTRL_EXT_SEL    0
`define CTRL_OSC_SLOW   1
`define CTRL_DECOMP     2
`define CTRL_CLAMP      3
`define CTRL_SOFT_RST   4
`define CTRL_W          5
`define CTRL_RST        5'h00

// status fields
`define ST_PAST_TC      0
`define ST_CHAIN_ON     1
`define ST_ISP          2
`define ST_INT_RST      3
`define ST_DATA_OE      4
`define ST_ADDR_LSB     16

// jtag instruction codes
`define IR_W            8
`define IR_BYPASS       8'hff
`define IR_CONFIG       8'h0e
`define IR_PROGRAMMING_MODE_ACTIVE        8'h0b

// synchronised pin levels after reset: {tdi,tms,tck,ce_n,oe_reset,ext_clk}
`define PIN_RST         6'h04

`endif

// [logic/tap_controller.v]
// jtag test access port state machine with instruction and bypass registers
`timescale 1ns/1ps
`default_nettype none
`include "config_prom_map.vh"

module tap_controller (
  input  wire                clk,
  input  wire                rstn,
  input  wire                tck_rise,
  input  wire                tck_fall,
  input  wire                tms,
  input  wire                tdi,
  output reg                 tdo,
  output reg                 tdo_oe,
  output reg                 config_req,
  output wire                programming_mode_active
);

  localparam [3:0] ST_RESET = 4'h0, ST_IDLE  = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PA_DR = 4'h6, ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UP_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc, ST_PA_IR = 4'hd, ST_EX2_IR = 4'he, ST_UP_IR = 4'hf;

  reg [3:0]       state_q;
  reg [3:0]       state_d;
  reg [`IR_W-1:0] ir_q;
  reg [`IR_W-1:0] ir_sh_q;
  reg             byp_q;

  assign programming_mode_active = (ir_q == `IR_PROGRAMMING_MODE_ACTIVE);

  //////////////////////////////////////////////////////////////////////////
  // next state from tms
  always @* begin
    case (state_q)
      ST_RESET:  state_d = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_d = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_d = tms ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  state_d = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_d = tms ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  state_d = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_d = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_d = tms ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  state_d = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_d = tms ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  state_d = tms ? ST_SEL_DR : ST_IDLE;
      default:   state_d = ST_RESET;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // state and registers move on test clock rising edges
  always @(posedge clk) begin
    config_req <= 1'b0;
    if (!rstn) begin
      state_q <= ST_RESET;
      ir_q    <= `IR_BYPASS;
      ir_sh_q <= `IR_BYPASS;
      byp_q   <= 1'b0;
    end else if (tck_rise) begin
      state_q <= state_d;
      case (state_q)
        ST_RESET:  ir_q    <= `IR_BYPASS;
        ST_CAP_IR: ir_sh_q <= {{(`IR_W-2){1'b0}}, 2'b01};
        ST_SH_IR:  ir_sh_q <= {tdi, ir_sh_q[`IR_W-1:1]};
        ST_CAP_DR: byp_q   <= 1'b0;
        ST_SH_DR:  byp_q   <= tdi;
        ST_UP_IR: begin
          ir_q       <= ir_sh_q;
          config_req <= (ir_sh_q == `IR_CONFIG);
        end
        default:   byp_q   <= byp_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // tdo changes on falling test clock, driven only while shifting
  always @(posedge clk) begin
    if (!rstn) begin
      tdo    <= 1'b1;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (state_q == ST_SH_IR) ? ir_sh_q[0] : byp_q;
      tdo_oe <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
    end
  end

endmodule // tap_controller

`default_nettype wire

// [logic/config_prom_readout.v]
// serial configuration prom readout with cascade, oscillator and jtag
`timescale 1ns/1ps
`default_nettype none
`include "config_prom_map.vh"

module config_prom_readout #(
  parameter MEM_WORDS = 64,
  parameter MEM_AW    = 6,
  parameter AW        = 11
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        external_clock_in,
  input  wire        ce_n,
  input  wire        oe_reset_in,
  output wire        oe_reset_out,
  output wire        oe_reset_oe,
  input  wire        decomp_data_ready,
  output reg         config_clock_out,
  output reg         serial_data_out,
  output reg         serial_data_oe,
  output reg         chain_enable_out_n,
  output wire        reconfig_pulse_n,
  output wire        reconfig_pulse_oe,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output wire        tdo,
  output wire        tdo_oe
);

  localparam NP = 6;
  // integer timing counts, cut to their counter widths where used
  localparam [NP-1:0] PIN_RST_V  = `PIN_RST;
  localparam integer  OSC_FAST_I = `OSC_FAST_CYC - 1;
  localparam integer  OSC_SLOW_I = `OSC_SLOW_CYC - 1;
  localparam integer  RST_HOLD_I = `RST_HOLD_CYC;
  localparam integer  CF_PULSE_I = `CF_PULSE_CYC;

  // true once the last two synchroniser stages agree
  function agree;
    input a;
    input b;
    begin
      agree = (a == b);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // three-stage pin synchronisers with agreement filter
  wire [NP-1:0] pin_raw = {tdi, tms, tck, ce_n, oe_reset_in, external_clock_in};
  reg  [NP-1:0] s1_q;
  reg  [NP-1:0] s2_q;
  reg  [NP-1:0] s3_q;
  reg  [NP-1:0] lvl_q;
  reg  [NP-1:0] lvl_p_q;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_sync
      // one pin's chain
      always @(posedge clk) begin
        if (!rstn) begin
          s1_q[gi]    <= PIN_RST_V[gi];
          s2_q[gi]    <= PIN_RST_V[gi];
          s3_q[gi]    <= PIN_RST_V[gi];
          lvl_q[gi]   <= PIN_RST_V[gi];
          lvl_p_q[gi] <= PIN_RST_V[gi];
        end else begin
          s1_q[gi]    <= pin_raw[gi];
          s2_q[gi]    <= s1_q[gi];
          s3_q[gi]    <= s2_q[gi];
          if (agree(s2_q[gi], s3_q[gi]))
            lvl_q[gi] <= s3_q[gi];
          lvl_p_q[gi] <= lvl_q[gi];
        end
      end
    end
  endgenerate

  wire ext_lvl  = lvl_q[0];
  wire ext_rise = lvl_q[0] & ~lvl_p_q[0];
  wire oe_hi    = lvl_q[1];
  wire ce_hi    = lvl_q[2];
  wire tck_rise = lvl_q[3] & ~lvl_p_q[3];
  wire tck_fall = ~lvl_q[3] & lvl_p_q[3];

  //////////////////////////////////////////////////////////////////////////
  // registers and storage
  reg [`CTRL_W-1:0] ctrl_q;
  reg [AW-1:0]      term_q;
  reg [MEM_AW-1:0]  mem_addr_q;
  reg [31:0]        mem [0:MEM_WORDS-1];
  reg [AW-1:0]      addr_q;
  reg               past_tc_q;

  wire ext_sel   = ctrl_q[`CTRL_EXT_SEL];
  wire decomp_en = ctrl_q[`CTRL_DECOMP];
  wire clamp     = ctrl_q[`CTRL_CLAMP];

  //////////////////////////////////////////////////////////////////////////
  // jtag tap and reconfiguration pulse
  wire config_req;
  wire programming_mode_active;
  reg  [7:0] cf_cnt_q;

  tap_controller u_tap (
    .clk                     (clk),
    .rstn                    (rstn),
    .tck_rise                (tck_rise),
    .tck_fall                (tck_fall),
    .tms                     (lvl_q[4]),
    .tdi                     (lvl_q[5]),
    .tdo                     (tdo),
    .tdo_oe                  (tdo_oe),
    .config_req              (config_req),
    .programming_mode_active (programming_mode_active)
  );

  // open-drain low pulse of fixed width
  always @(posedge clk) begin
    if (!rstn)
      cf_cnt_q <= 8'h00;
    else if (config_req)
      cf_cnt_q <= CF_PULSE_I[7:0];
    else if (cf_cnt_q != 8'h00)
      cf_cnt_q <= cf_cnt_q - 8'h01;
  end

  assign reconfig_pulse_n  = 1'b0;
  assign reconfig_pulse_oe = (cf_cnt_q != 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // internal reset: held after rstn release or by software
  reg [7:0] rst_cnt_q;

  always @(posedge clk) begin
    if (!rstn)
      rst_cnt_q <= RST_HOLD_I[7:0];
    else if (rst_cnt_q != 8'h00)
      rst_cnt_q <= rst_cnt_q - 8'h01;
  end

  wire int_rst = (rst_cnt_q != 8'h00) | ctrl_q[`CTRL_SOFT_RST];

  assign oe_reset_out = 1'b0;
  assign oe_reset_oe  = int_rst;

  //////////////////////////////////////////////////////////////////////////
  // internal oscillator, stopped in standby
  reg [1:0] osc_cnt_q;
  wire [1:0] osc_last = ctrl_q[`CTRL_OSC_SLOW] ? OSC_SLOW_I[1:0] : OSC_FAST_I[1:0];
  wire osc_tick = (osc_cnt_q == 2'd0) & ~ce_hi;

  always @(posedge clk) begin
    if (!rstn || ce_hi)
      osc_cnt_q <= 2'd0;
    else if (osc_cnt_q >= osc_last)
      osc_cnt_q <= 2'd0;
    else
      osc_cnt_q <= osc_cnt_q + 2'd1;
  end

  //////////////////////////////////////////////////////////////////////////
  // clock out: follows source, or gated half rate when decompressing
  reg  half_q;
  reg  clk_out_d;
  wire src_event = ext_sel ? ext_rise : (osc_tick & half_q);

  always @* begin
    if (decomp_en && !decomp_data_ready)
      clk_out_d = 1'b1;
    else if (decomp_en)
      clk_out_d = src_event ? ~config_clock_out : config_clock_out;
    else if (ext_sel)
      clk_out_d = ext_lvl;
    else
      clk_out_d = osc_tick ? ~config_clock_out : config_clock_out;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      config_clock_out <= 1'b1;
      half_q           <= 1'b0;
    end else begin
      config_clock_out <= clk_out_d;
      if (osc_tick)
        half_q <= ~half_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address counter and terminal count
  wire adv_src = (ext_sel && !decomp_en) ? ext_rise : (clk_out_d & ~config_clock_out);
  wire enabled = ~ce_hi & oe_hi & ~int_rst;
  wire adv     = adv_src & enabled;

  always @(posedge clk) begin
    if (!rstn || !enabled) begin
      addr_q    <= {AW{1'b0}};
      past_tc_q <= 1'b0;
    end else if (adv) begin
      addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
      if (addr_q == term_q)
        past_tc_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial data, output enable and chain enable
  wire [31:0] cur_word = mem[addr_q[AW-1:5]];
  wire float_isp = programming_mode_active & ~clamp;

  always @(posedge clk) begin
    if (!rstn) begin
      serial_data_out    <= 1'b0;
      serial_data_oe     <= 1'b0;
      chain_enable_out_n <= 1'b1;
    end else begin
      serial_data_out    <= cur_word[addr_q[4:0]];
      serial_data_oe     <= enabled & ~past_tc_q & ~float_isp;
      chain_enable_out_n <= ~(enabled & past_tc_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  reg        dph_q;
  reg        dwr_q;
  reg [7:0]  dadr_q;
  wire       aph = hsel & htrans[1] & hready;
  wire [31:0] status = {{(16-AW){1'b0}}, addr_q, 11'h000, serial_data_oe, int_rst,
                        programming_mode_active, ~chain_enable_out_n, past_tc_q};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture and read data
  always @(posedge clk) begin
    if (!rstn) begin
      dph_q  <= 1'b0;
      dwr_q  <= 1'b0;
      dadr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      dph_q  <= aph;
      dwr_q  <= hwrite;
      dadr_q <= haddr[7:0];
      if (aph && !hwrite) begin
        case (haddr[7:0])
          `REG_CTRL:     hrdata <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
          `REG_STATUS:   hrdata <= status;
          `REG_TERM:     hrdata <= {{(32-AW){1'b0}}, term_q};
          `REG_MEM_ADDR: hrdata <= {{(32-MEM_AW){1'b0}}, mem_addr_q};
          `REG_MEM_DATA: hrdata <= mem[mem_addr_q];
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // data phase writes
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl_q     <= `CTRL_RST;
      term_q     <= {AW{1'b1}};
      mem_addr_q <= {MEM_AW{1'b0}};
    end else if (dph_q && dwr_q) begin
      case (dadr_q)
        `REG_CTRL:     ctrl_q     <= hwdata[`CTRL_W-1:0];
        `REG_TERM:     term_q     <= hwdata[AW-1:0];
        `REG_MEM_ADDR: mem_addr_q <= hwdata[MEM_AW-1:0];
        `REG_MEM_DATA: mem_addr_q <= mem_addr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
        default:       ctrl_q     <= ctrl_q;
      endcase
    end
  end

  // bitstream storage write port
  always @(posedge clk) begin
    if (dph_q && dwr_q && dadr_q == `REG_MEM_DATA)
      mem[mem_addr_q] <= hwdata;
  end

endmodule // config_prom_readout

`default_nettype wire

// [tb/config_prom_readout_asserts.sv]
// pin-level checks for the prom readout
`timescale 1ns/1ps
`default_nettype none
module config_prom_readout_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce_n,
  input wire logic oe_reset_in,
  input wire logic oe_reset_out,
  input wire logic oe_reset_oe,
  input wire logic serial_data_oe,
  input wire logic chain_enable_out_n,
  input wire logic reconfig_pulse_n,
  input wire logic reconfig_pulse_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // cascade and data pin
  a_chain_off_ce: assert property (ce_n [*8] |-> chain_enable_out_n)
    else $error("chain enable low while deselected");
  a_float_ce: assert property (ce_n [*8] |-> !serial_data_oe)
    else $error("data driven while deselected");
  a_float_oe_low: assert property (!oe_reset_in [*8] |-> !serial_data_oe)
    else $error("data driven while enable pin low");
  a_chain_low_cause: assert property ($fell(chain_enable_out_n) |-> !ce_n && oe_reset_in)
    else $error("chain enable fell while disabled");
  a_chain_stops_data: assert property (!chain_enable_out_n |-> !serial_data_oe)
    else $error("data driven past terminal count");
  ////////////////////////////////////////
  // open-drain pins
  a_reset_pull_hold: assert property ($rose(rstn) |-> oe_reset_oe [*8])
    else $error("enable pin not pulled after reset");
  a_pull_level: assert property (oe_reset_oe |-> !oe_reset_out)
    else $error("enable pin pulled high");
  a_float_int_rst: assert property (oe_reset_oe [*3] |-> !serial_data_oe)
    else $error("data driven in internal reset");
  a_cf_width: assert property ($rose(reconfig_pulse_oe) |-> ##19 reconfig_pulse_oe ##1 !reconfig_pulse_oe)
    else $error("reconfig pulse width wrong");
  a_cf_level: assert property (reconfig_pulse_oe |-> !reconfig_pulse_n)
    else $error("reconfig pin pulled high");
endmodule // config_prom_readout_asserts

bind config_prom_readout config_prom_readout_asserts i_chk (.clk, .rstn, .ce_n,
  .oe_reset_in, .oe_reset_out, .oe_reset_oe, .serial_data_oe, .chain_enable_out_n,
  .reconfig_pulse_n, .reconfig_pulse_oe);
`default_nettype wire

// [tb/fpga_cfg_model.sv]
// far-side loader model: link clock, bit capture, open-drain reset pin
`timescale 1ns/1ps
`default_nettype none
module fpga_cfg_model (
  input  wire logic        run,
  input  wire logic        sdo,
  input  wire logic        sdo_oe,
  input  wire logic        hold_low,
  input  wire logic        dev_pull,
  output var  logic        ext_clk,
  output wire logic        oe_pin,
  output var  logic [63:0] bits,
  output var  int          nbits
);
  // pull-up: low whenever either side pulls
  assign oe_pin = !(hold_low || dev_pull);
  // clock only within frames, bits taken at rising edge
  initial begin
    ext_clk = 1'b0;
    nbits = 0;
    bits = '0;
    forever begin
      wait (run);
      #3;
      while (run) begin
        #100 ext_clk = 1'b1;
        if (sdo_oe) begin
          bits[nbits] = sdo;
          nbits++;
        end
        #100 ext_clk = 1'b0;
      end
    end
  end
endmodule // fpga_cfg_model
`default_nettype wire

// [tb/config_prom_readout_tb.sv]
// self-checking bench for the prom readout
`timescale 1ns/1ps
`default_nettype none
`include "config_prom_map.vh"
module config_prom_readout_tb;
  logic        clk, rstn, hsel, hwrite, hready, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, d, w0, w1;
  logic [1:0]  htrans;
  logic        external_clock_in, ce_n, oe_reset_in, oe_reset_out, oe_reset_oe;
  logic        decomp_data_ready, config_clock_out, serial_data_out, serial_data_oe;
  logic        chain_enable_out_n, reconfig_pulse_oe, tck, tms, tdi, run, hold_low;
  logic        tdo, tdo_oe;
  logic        saw_cf = 1'b0;
  logic [63:0] bits;
  int          nbits, n, r;
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;

  assign hready = hreadyout;
  config_prom_readout i_dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hreadyout, .hresp(), .hrdata, .external_clock_in, .ce_n,
    .oe_reset_in, .oe_reset_out, .oe_reset_oe, .decomp_data_ready, .config_clock_out,
    .serial_data_out, .serial_data_oe, .chain_enable_out_n, .reconfig_pulse_n(),
    .reconfig_pulse_oe, .tck, .tms, .tdi, .tdo, .tdo_oe);
  fpga_cfg_model i_fpga (.run, .sdo(serial_data_out), .sdo_oe(serial_data_oe), .hold_low,
    .dev_pull(oe_reset_oe), .ext_clk(external_clock_in), .oe_pin(oe_reset_in), .bits,
    .nbits);

  ////////////////////////////////////////
  // clock, watchdog, pulse monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (reconfig_pulse_oe === 1'b1) saw_cf <= 1'b1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////
  // helpers
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ahb(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    ahb(1'b0, a, 32'h0, v);
  endtask
  task automatic rises(input int c, output int cnt);
    logic prev;
    step(4);
    cnt = 0;
    prev = config_clock_out;
    repeat (c) begin
      step(1);
      if (!prev && config_clock_out) cnt++;
      prev = config_clock_out;
    end
  endtask
  task automatic tk(input logic m, input logic b);
    tms <= m;
    tdi <= b;
    step(4);
    tck <= 1'b1;
    step(4);
    tck <= 1'b0;
  endtask
  task automatic ir_load(input logic [7:0] code);
    repeat (5) tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b1, 1'b0);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b0);
    // shifting instruction: captured lsb on tdo, driven
    step(6);
    chk(tdo_oe, 1);
    chk(tdo, 1);
    for (int i = 0; i < 8; i++) tk(i == 7, code[i]);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    // let the last synced test clock edges take effect
    step(6);
    chk(tdo_oe, 0);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    {rstn, hsel, hwrite, run, hold_low, tck, tdi, decomp_data_ready} = '0;
    {ce_n, tms} = 2'b11;
    {haddr, hwdata, htrans} = '0;
    void'($urandom(32'hf024));
    step(20);
    rstn <= 1'b1;
    step(20);
    w0 = $urandom;
    w1 = $urandom;
    n = 33 + $urandom % 31;
    wr(`REG_MEM_ADDR, 32'h0);
    wr(`REG_MEM_DATA, w0);
    wr(`REG_MEM_DATA, w1);
    wr(`REG_TERM, 32'(n - 1));
    wr(`REG_CTRL, 32'h1);
    ce_n <= 1'b0;
    step(10);
    run <= 1'b1;
    while (nbits < n) step(1);
    run <= 1'b0;
    step(12);
    chk(bits, {w1, w0} & ((64'h1 << n) - 1));
    chk(chain_enable_out_n, 0);
    chk(serial_data_oe, 0);
    hold_low <= 1'b1;
    step(8);
    chk(chain_enable_out_n, 1);
    chk(serial_data_oe, 0);
    rd(`REG_STATUS, d);
    chk(d[26:16], 0);
    hold_low <= 1'b0;
    step(8);
    chk(serial_data_oe, 1);
    run <= 1'b1;
    step(40);
    run <= 1'b0;
    ce_n <= 1'b1;
    step(8);
    chk(serial_data_oe, 0);
    rd(`REG_STATUS, d);
    chk(d[26:16], 0);
    ce_n <= 1'b0;
    wr(`REG_CTRL, 32'h0);
    rises(80, r);
    chk(r, 40);
    wr(`REG_CTRL, 32'h2);
    rises(80, r);
    chk(r, 20);
    wr(`REG_CTRL, 32'h4);
    decomp_data_ready <= 1'b1;
    rises(80, r);
    chk(r, 20);
    decomp_data_ready <= 1'b0;
    rises(40, r);
    chk(r, 0);
    chk(config_clock_out, 1);
    ir_load(`IR_CONFIG);
    chk(saw_cf, 1);
    ce_n <= 1'b1;
    step(8);
    ce_n <= 1'b0;
    wr(`REG_CTRL, 32'h1);
    ir_load(`IR_PROGRAMMING_MODE_ACTIVE);
    rd(`REG_STATUS, d);
    chk(d[`ST_ISP], 1);
    chk(serial_data_oe, 0);
    wr(`REG_CTRL, 32'h9);
    step(8);
    chk(serial_data_oe, 1);
    // software-held internal reset pulls the enable pin
    wr(`REG_CTRL, 32'h19);
    step(8);
    chk(oe_reset_oe, 1);
    chk(oe_reset_in, 0);
    chk(serial_data_oe, 0);
    wr(`REG_CTRL, 32'h9);
    step(8);
    chk(oe_reset_oe, 0);
    chk(serial_data_oe, 1);
    tally_and_finish;
  end
endmodule // config_prom_readout_tb
`default_nettype wire
